/* pkg/ros_pkg.sv */
package ros_pkg;

    // tick qualification: a level seen on this many slow ticks in a row
    localparam logic [1:0]  QUAL_TICKS      = 2'h3;
    // slow ticks that a power-fail reset pulse stays low
    localparam logic [1:0]  PF_HOLD_TICKS   = 2'h2;
    // core clock rate and pll lock wait, in their own units
    localparam int          CLK_FREQ_MHZ    = 10;
    localparam int          PLL_LOCK_US     = 250;
    // least time, so whole cycles: us times MHz is already exact
    localparam int          PLL_CNT_W       = 12;
    localparam logic [11:0] PLL_LOCK_CYCLES = 12'(PLL_LOCK_US * CLK_FREQ_MHZ);

    // pin inputs that travel together through the synchroniser
    typedef struct packed {
        logic slow_clk;   // slow crystal clock, sampled as data
        logic por_n;      // power-on reset, active low
        logic ureset_n;   // user reset, active low
        logic pfail_n;    // power fail, active low
        logic wake;       // wake request, active high
        logic fast_ok;    // fast oscillator reported stable
    } ros_pins_type;

    // gate state, one-hot
    typedef enum logic [1:0] {
        ST_OFF = 2'b01,
        ST_RUN = 2'b10
    } ros_state_type;

endpackage : ros_pkg

/* logic/ros_reset_sequencer.sv */
module ros_reset_sequencer
    import ros_pkg::*;
(
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic slow_crystal_clock,
    input  wire logic power_on_reset_n,
    input  wire logic user_reset_n,
    input  wire logic power_fail_n,
    input  wire logic wake_request,
    input  wire logic fast_osc_stable,
    output logic      system_reset_output_n,
    output logic      oscillator_clock_gate,
    output logic      pll_lock_done
);

    ros_pins_type         pins_raw;     // raw pins gathered
    ros_pins_type         sync1_q;      // first stage, read by stage two only
    ros_pins_type         sync2_q;      // safe copy of the pins
    logic                 slow_prev_q;  // last synced slow clock level
    logic                 tick_q;       // one-cycle pulse per slow period
    logic                 tick_d;
    logic [1:0]           ur_cnt_q;     // ticks user reset seen low
    logic [1:0]           ur_cnt_d;
    logic [1:0]           pf_cnt_q;     // ticks power fail seen low
    logic [1:0]           pf_cnt_d;
    logic [1:0]           wk_cnt_q;     // ticks wake seen high
    logic [1:0]           wk_cnt_d;
    logic [1:0]           pf_hold_q;    // ticks left of power-fail pulse
    logic [1:0]           pf_hold_d;
    ros_state_type        state_q;      // clock gate state
    ros_state_type        state_d;
    logic                 rst_out_q;    // reset output, active low
    logic                 rst_out_d;
    logic [PLL_CNT_W-1:0] pll_cnt_q;    // cycles since fast osc stable
    logic [PLL_CNT_W-1:0] pll_cnt_d;
    logic                 pll_done_q;
    logic                 pll_done_d;
    logic                 pf_fire;      // power fail just qualified
    logic                 ur_active;    // user reset qualified

    assign pins_raw = '{slow_clk: slow_crystal_clock,
                        por_n:    power_on_reset_n,
                        ureset_n: user_reset_n,
                        pfail_n:  power_fail_n,
                        wake:     wake_request,
                        fast_ok:  fast_osc_stable};

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            // power-on held asserted so reset out cannot blink high
            // while the stages fill; crystal seen high so the first
            // tick after reset comes from a real rising edge
            sync1_q <= '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
            sync2_q <= '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
        end else begin
            sync1_q <= pins_raw;
            sync2_q <= sync1_q;
        end
    end

    // next-value logic for all sequencer state except slow_prev_q
    always_comb begin
        // rising edge of the slow crystal gives the period tick
        tick_d    = sync2_q.slow_clk & ~slow_prev_q;
        ur_cnt_d  = ur_cnt_q;
        pf_cnt_d  = pf_cnt_q;
        wk_cnt_d  = wk_cnt_q;
        pf_hold_d = pf_hold_q;
        pf_fire   = 1'b0;
        // counters advance on slow ticks only
        if (tick_q) begin
            // saturating counts; a level must be seen on three
            // ticks, so the act lands 2 to 3 periods after the edge
            ur_cnt_d = sync2_q.ureset_n ? 2'h0 :
                       (ur_cnt_q == QUAL_TICKS ? ur_cnt_q : ur_cnt_q + 2'h1);
            pf_cnt_d = sync2_q.pfail_n ? 2'h0 :
                       (pf_cnt_q == QUAL_TICKS ? pf_cnt_q : pf_cnt_q + 2'h1);
            wk_cnt_d = !sync2_q.wake ? 2'h0 :
                       (wk_cnt_q == QUAL_TICKS ? wk_cnt_q : wk_cnt_q + 2'h1);
            // power-fail pulse counts down per tick
            if (pf_hold_q != 2'h0) begin
                pf_hold_d = pf_hold_q - 2'h1;
            end
            // a fresh qualification restarts the pulse
            if (pf_cnt_q != QUAL_TICKS && pf_cnt_d == QUAL_TICKS) begin
                pf_fire   = 1'b1;
                pf_hold_d = PF_HOLD_TICKS;
            end
        end
        ur_active = (ur_cnt_d == QUAL_TICKS);
        // reset out follows user reset, power fail, power-on
        // release on the first tick that sees user reset high
        rst_out_d = sync2_q.por_n & ~ur_active & (pf_hold_d == 2'h0);

        // gate drops on any qualified trigger
        state_d = state_q;
        case (state_q)
            ST_OFF: begin
                if (wk_cnt_d == QUAL_TICKS && sync2_q.por_n &&
                    !ur_active && pf_cnt_d == 2'h0) begin
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                if (!sync2_q.por_n || ur_active || pf_fire ||
                    pf_cnt_d == QUAL_TICKS) begin
                    state_d = ST_OFF;
                end
            end
            default: begin
                state_d = ST_OFF;
            end
        endcase

        // pll lock wait restarts whenever fast osc drops
        pll_cnt_d  = pll_cnt_q;
        pll_done_d = pll_done_q;
        if (!sync2_q.fast_ok) begin
            pll_cnt_d  = '0;
            pll_done_d = 1'b0;
        end else if (pll_cnt_q != PLL_LOCK_CYCLES) begin
            pll_cnt_d = pll_cnt_q + 12'h001;
        end else begin
            pll_done_d = 1'b1;
        end
    end

    // registers only; reset holds the system in reset, gate off
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            // matches the synchroniser's reset level: no false tick
            slow_prev_q <= 1'b1;
            tick_q      <= 1'b0;
            ur_cnt_q    <= 2'h0;
            pf_cnt_q    <= 2'h0;
            wk_cnt_q    <= 2'h0;
            pf_hold_q   <= 2'h0;
            state_q     <= ST_OFF;
            rst_out_q   <= 1'b0;
            pll_cnt_q   <= '0;
            pll_done_q  <= 1'b0;
        end else begin
            slow_prev_q <= sync2_q.slow_clk;
            tick_q      <= tick_d;
            ur_cnt_q    <= ur_cnt_d;
            pf_cnt_q    <= pf_cnt_d;
            wk_cnt_q    <= wk_cnt_d;
            pf_hold_q   <= pf_hold_d;
            state_q     <= state_d;
            rst_out_q   <= rst_out_d;
            pll_cnt_q   <= pll_cnt_d;
            pll_done_q  <= pll_done_d;
        end
    end

    // outputs straight from flops
    assign system_reset_output_n = rst_out_q;
    // run bit of the one-hot state flop drives the gate directly
    assign oscillator_clock_gate = state_q[1];
    assign pll_lock_done         = pll_done_q;

    // user reset seen on the third tick forces reset out
    a_ur_assert: assert property (
        @(posedge clk) disable iff (!resetn)
        tick_q && ur_cnt_q == 2'h2 && !sync2_q.ureset_n |=> !rst_out_q)
        else $error("reset out missed qualified user reset");

    // first tick with user reset high frees reset out
    a_ur_release: assert property (
        @(posedge clk) disable iff (!resetn)
        tick_q && ur_cnt_q == QUAL_TICKS && sync2_q.ureset_n &&
        sync2_q.por_n && sync2_q.pfail_n && pf_hold_q == 2'h0
        |=> rst_out_q)
        else $error("reset out not released after user reset");

    // qualified wake turns the clock gate on
    a_wk_gate_on: assert property (
        @(posedge clk) disable iff (!resetn)
        tick_q && wk_cnt_q == 2'h2 && sync2_q.wake && sync2_q.por_n &&
        sync2_q.ureset_n && sync2_q.pfail_n && pf_cnt_q == 2'h0
        |=> oscillator_clock_gate)
        else $error("clock gate not on after wake");

    // user reset qualification drops the gate
    a_ur_gate_off: assert property (
        @(posedge clk) disable iff (!resetn)
        tick_q && ur_cnt_q == 2'h2 && !sync2_q.ureset_n
        |=> !oscillator_clock_gate)
        else $error("clock gate kept on in user reset");

    // power fail qualification drops the gate
    a_pf_gate_off: assert property (
        @(posedge clk) disable iff (!resetn)
        tick_q && pf_cnt_q == 2'h2 && !sync2_q.pfail_n
        |=> !oscillator_clock_gate)
        else $error("clock gate kept on in power fail");

    // power fail pulse starts low with the hold loaded and is still low one cycle later
    a_pf_pulse: assert property (
        @(posedge clk) disable iff (!resetn)
        tick_q && pf_cnt_q == 2'h2 && !sync2_q.pfail_n
        |=> !rst_out_q && pf_hold_q == PF_HOLD_TICKS
            ##1 (!rst_out_q throughout !tick_q[*1]))
        else $error("power fail reset pulse wrong");

    // pll done rises only after the count has reached the full lock time
    a_pll_wait: assert property (
        @(posedge clk) disable iff (!resetn)
        $rose(pll_lock_done) |-> $past(pll_cnt_q) == PLL_LOCK_CYCLES)
        else $error("pll done before lock time");

    // slow tick is a single-cycle pulse
    a_tick_single: assert property (
        @(posedge clk) disable iff (!resetn)
        tick_q |=> !tick_q)
        else $error("slow tick longer than one cycle");

endmodule : ros_reset_sequencer

/* sim/ros_board_model.sv */
module ros_board_model (
    input  wire logic clk,
    output logic      slow_crystal_clock,
    output logic      power_on_reset_n,
    output logic      user_reset_n,
    output logic      power_fail_n,
    output logic      wake_request
);
    timeunit 1ns;
    timeprecision 1ns;
    parameter int SLOW_CYC = 305;   // clk cycles per slow period
    // 1 Hz period shortened to keep the run short; the block never counts it
    parameter int HZ1_CYC  = 2000;
    longint       last_t;           // time of the last pin change
    logic         long_gap;         // last release asks for the 1 Hz gap

    // power-on reset low while the crystal settles
    initial begin
        slow_crystal_clock = 1'b0;
        power_on_reset_n   = 1'b0;
        user_reset_n       = 1'b1;
        power_fail_n       = 1'b1;
        wake_request       = 1'b0;
        long_gap           = 1'b1;
        last_t             = 0;
    end

    // free-running crystal, unrelated in phase to clk
    always #15259 slow_crystal_clock = ~slow_crystal_clock;

    // pin 0 power-on, 1 user reset, 2 power fail, 3 wake
    task automatic drive(input int pin, input logic v);
        int need;
        // gap before wake, wake held four periods
        if (pin == 3)
            need = v ? (long_gap ? 2 * HZ1_CYC : 2 * SLOW_CYC + 20)
                     : 4 * SLOW_CYC + 20;
        // triggers held at least four periods
        else
            need = v ? 4 * SLOW_CYC + 20 : 0;
        while ($time - last_t < 100 * need) @(negedge clk);
        case (pin)
            0: power_on_reset_n = v;
            1: user_reset_n     = v;
            2: power_fail_n     = v;
            default: wake_request = v;
        endcase
        if (pin != 3 && v) long_gap = (pin != 1);
        last_t = $time;
    endtask : drive
endmodule : ros_board_model

/* sim/reset_output_sequencer_test.sv */
module reset_output_sequencer_test
    import ros_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int P  = 305;        // clk cycles per slow period
    localparam int HI = 4 * P + 8;  // four periods plus sync slack
    logic clk, resetn, fast_osc_stable, slow_crystal_clock;
    logic power_on_reset_n, user_reset_n, power_fail_n, wake_request;
    logic system_reset_output_n, oscillator_clock_gate, pll_lock_done;
    int   n_errors, checks_done;    // mismatches and comparisons

    ros_reset_sequencer ros_reset_sequencer_inst (.clk, .resetn,
        .slow_crystal_clock, .power_on_reset_n, .user_reset_n,
        .power_fail_n, .wake_request, .fast_osc_stable,
        .system_reset_output_n, .oscillator_clock_gate, .pll_lock_done);
    ros_board_model #(.SLOW_CYC(P)) ros_board_model_inst (.clk,
        .slow_crystal_clock, .power_on_reset_n, .user_reset_n,
        .power_fail_n, .wake_request);

    // core clock, 100 ns period
    always #50 clk = ~clk;

    task automatic check(input string name, input logic seen,
                         input logic exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %b seen %b", name, exp, seen);
        end
    endtask : check

    task automatic results();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : results

    // output by index: 0 reset out, 1 clock gate, 2 pll lock
    function automatic logic outv(input int s);
        if (s == 0) return system_reset_output_n;
        if (s == 1) return oscillator_clock_gate;
        return pll_lock_done;
    endfunction : outv

    // bounded wait; the change must land inside lo..hi cycles
    task automatic await(input string name, input int s, input logic v,
                         input int lo, input int hi);
        int n;
        n = 0;
        while (outv(s) !== v && n <= hi) begin
            @(negedge clk);
            n++;
        end
        check(name, n >= lo && n <= hi, 1'b1);
        if (n > hi) results();
    endtask : await

    task automatic t_power_on();
        check("rst_in_reset", system_reset_output_n, 1'b0);
        check("pll_in_reset", pll_lock_done, 1'b0);
        resetn = 1'b1;
        // reset out must stay low on each of the next 10 falling edges while the pin is low
        repeat (10) begin
            @(negedge clk);
            check("rst_por_low", system_reset_output_n, 1'b0);
        end
        ros_board_model_inst.drive(0, 1'b1);
        await("rst_por_free", 0, 1'b1, 0, 5);
        check("gate_pre_wake", oscillator_clock_gate, 1'b0);
    endtask : t_power_on

    task automatic t_wake();
        ros_board_model_inst.drive(3, 1'b1);
        await("gate_on_wake", 1, 1'b1, 2 * P, HI);
        ros_board_model_inst.drive(3, 1'b0);
        check("gate_after_wake", oscillator_clock_gate, 1'b1);
    endtask : t_wake

    task automatic t_user_reset();
        ros_board_model_inst.drive(1, 1'b0);
        await("rst_on_ureset", 0, 1'b0, 2 * P, HI);
        check("gate_off_ureset", oscillator_clock_gate, 1'b0);
        ros_board_model_inst.drive(1, 1'b1);
        await("rst_free_ureset", 0, 1'b1, 0, 2 * P + 8);
        t_wake();
    endtask : t_user_reset

    task automatic t_power_fail();
        ros_board_model_inst.drive(2, 1'b0);
        await("rst_on_pfail", 0, 1'b0, 2 * P, HI);
        check("gate_off_pfail", oscillator_clock_gate, 1'b0);
        await("rst_pulse_pfail", 0, 1'b1, 2 * P - 8, 2 * P + 8);
        ros_board_model_inst.drive(2, 1'b1);
        t_wake();
    endtask : t_power_fail

    task automatic t_por_mid();
        ros_board_model_inst.drive(0, 1'b0);
        await("rst_on_por", 0, 1'b0, 0, 5);
        check("gate_off_por", oscillator_clock_gate, 1'b0);
        ros_board_model_inst.drive(0, 1'b1);
        await("rst_free_por", 0, 1'b1, 0, 5);
    endtask : t_por_mid

    task automatic t_pll();
        fast_osc_stable = 1'b1;
        await("pll_lock", 2, 1'b1, int'(PLL_LOCK_CYCLES),
              int'(PLL_LOCK_CYCLES) + 8);
    endtask : t_pll

    // reset 20 cycles, then each scenario in turn
    initial begin
        clk             = 1'b0;
        resetn          = 1'b0;
        fast_osc_stable = 1'b0;
        n_errors        = 0;
        checks_done     = 0;
        repeat (20) @(negedge clk);
        t_power_on();
        t_wake();
        t_user_reset();
        t_power_fail();
        t_por_mid();
        t_pll();
        results();
    end
endmodule : reset_output_sequencer_test
